//--- design/smsec_top.sv
// Purpose: Max-address security state machine and its stored values
// Assumes: Request pulse comes from logic on REF_CLK_IN, so no synchroniser
// Notes:   PWR_ONN_IN is power-on reset; RSTN_IN is hardware/software reset
`timescale 1ns/1ps
`default_nettype none

module smsec_top import smsec_pkg::*; (
	input  wire logic                    REF_CLK_IN,
	input  wire logic                    PWR_ONN_IN,
	input  wire logic                    RSTN_IN,
	input  wire smsec_req_s              REQ_IN,
	output var  smsec_rsp_s              RSP_OUT,
	output var  logic [SMSEC_ADDR_W-1:0] MAX_ADDR_OUT,
	output var  logic                    SEC_ENABLED_OUT,
	output var  logic [1:0]              STATE_OUT
);

	// ------------------------------------------------------------
	// State and stored values
	// ------------------------------------------------------------
	smsec_state_e            state_q, state_d;
	logic [SMSEC_PW_W-1:0]   pw_q;
	logic [SMSEC_ADDR_W-1:0] max_q;
	logic                    abort_d;

	// ------------------------------------------------------------
	// Next state and abort decision
	// ------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		abort_d = 1'b0;
		if (REQ_IN.valid) begin
			case (state_q)
				SMSEC_INACTIVE: begin
					case (REQ_IN.cmd)
						SMSEC_CMD_SETPW:  state_d = SMSEC_UNLOCKED;
						SMSEC_CMD_LOCK,
						SMSEC_CMD_UNLOCK,
						SMSEC_CMD_FREEZE: abort_d = 1'b1;
						default:          state_d = state_q;
					endcase
				end
				SMSEC_UNLOCKED: begin
					case (REQ_IN.cmd)
						SMSEC_CMD_LOCK:   state_d = SMSEC_LOCKED;
						SMSEC_CMD_FREEZE: state_d = SMSEC_FROZEN;
						// Unlock is a no-op without error
						default:          state_d = state_q;
					endcase
				end
				SMSEC_LOCKED: begin
					case (REQ_IN.cmd)
						SMSEC_CMD_SETMAX,
						SMSEC_CMD_SETPW:  abort_d = 1'b1;
						SMSEC_CMD_UNLOCK: state_d = SMSEC_UNLOCKED;
						SMSEC_CMD_FREEZE: begin
							// Optional move; host is told not to do this
							if (SMSEC_FRZ_FROM_LK)
								state_d = SMSEC_FROZEN;
							else
								abort_d = 1'b1;
						end
						default:          state_d = state_q;
					endcase
				end
				default: begin
					// Only a power cycle leaves here
					if (REQ_IN.cmd != SMSEC_CMD_NONE)
						abort_d = 1'b1;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	// State and password survive RSTN_IN; only power-on clears them
	always_ff @(posedge REF_CLK_IN) begin
		if (!PWR_ONN_IN)
			state_q <= SMSEC_INACTIVE;
		else
			state_q <= state_d;
	end

	always_ff @(posedge REF_CLK_IN) begin
		if (!PWR_ONN_IN)
			pw_q <= SMSEC_PW_RST;
		else if (REQ_IN.valid && REQ_IN.cmd == SMSEC_CMD_SETPW && !abort_d)
			pw_q <= REQ_IN.pw;
	end

	always_ff @(posedge REF_CLK_IN) begin
		if (!PWR_ONN_IN)
			max_q <= SMSEC_MAX_RST;
		else if (REQ_IN.valid && REQ_IN.cmd == SMSEC_CMD_SETMAX && !abort_d)
			max_q <= REQ_IN.addr;
	end

	always_ff @(posedge REF_CLK_IN) begin
		if (!PWR_ONN_IN || !RSTN_IN) begin
			RSP_OUT <= '0;
		end else begin
			RSP_OUT.done    <= REQ_IN.valid && REQ_IN.cmd != SMSEC_CMD_NONE;
			RSP_OUT.aborted <= abort_d;
		end
	end

	always_ff @(posedge REF_CLK_IN) begin
		if (!PWR_ONN_IN)
			SEC_ENABLED_OUT <= 1'b0;
		else
			SEC_ENABLED_OUT <= (state_d != SMSEC_INACTIVE);
	end

	assign MAX_ADDR_OUT = max_q;
	assign STATE_OUT    = state_q;

	// ------------------------------------------------------------
	// Checks: identify bit and resets
	// ------------------------------------------------------------
	a_idbit_tracks: assert property (@(posedge REF_CLK_IN) disable iff (!PWR_ONN_IN)
		SEC_ENABLED_OUT == (state_q != SMSEC_INACTIVE))
		else $error("identify bit disagrees with state");

	a_idbit_clear: assert property (@(posedge REF_CLK_IN) disable iff (!PWR_ONN_IN)
		state_q == SMSEC_INACTIVE |-> !SEC_ENABLED_OUT)
		else $error("identify bit set while inactive");

	// No disable here: it must look at the first edge after power-on
	a_poweron_clear: assert property (@(posedge REF_CLK_IN)
		$rose(PWR_ONN_IN) |-> state_q == SMSEC_INACTIVE && pw_q == SMSEC_PW_RST
			&& !SEC_ENABLED_OUT)
		else $error("power-on did not clear state");

	a_pw_reset_keep: assert property (@(posedge REF_CLK_IN) disable iff (!PWR_ONN_IN)
		!RSTN_IN |=> $stable(pw_q) && $stable(state_q))
		else $error("reset changed password");

	// ------------------------------------------------------------
	// Checks: inactive and unlocked states
	// ------------------------------------------------------------
	a_inactive_abort: assert property (@(posedge REF_CLK_IN)
		disable iff (!PWR_ONN_IN || !RSTN_IN)
		REQ_IN.valid && state_q == SMSEC_INACTIVE && REQ_IN.cmd inside {SMSEC_CMD_LOCK,
		SMSEC_CMD_UNLOCK, SMSEC_CMD_FREEZE} |=> RSP_OUT.aborted && state_q == SMSEC_INACTIVE)
		else $error("inactive did not abort");

	a_setmax_exec: assert property (@(posedge REF_CLK_IN)
		disable iff (!PWR_ONN_IN || !RSTN_IN)
		REQ_IN.valid && REQ_IN.cmd == SMSEC_CMD_SETMAX
			&& state_q inside {SMSEC_INACTIVE, SMSEC_UNLOCKED}
		|=> !RSP_OUT.aborted && max_q == $past(REQ_IN.addr) && $stable(state_q))
		else $error("set max not executed");

	a_setpw_unlock: assert property (@(posedge REF_CLK_IN) disable iff (!PWR_ONN_IN)
		REQ_IN.valid && REQ_IN.cmd == SMSEC_CMD_SETPW && state_q == SMSEC_INACTIVE
		|=> state_q == SMSEC_UNLOCKED && pw_q == $past(REQ_IN.pw))
		else $error("set password did not unlock");

	a_setpw_replace: assert property (@(posedge REF_CLK_IN)
		disable iff (!PWR_ONN_IN || !RSTN_IN)
		REQ_IN.valid && REQ_IN.cmd == SMSEC_CMD_SETPW && state_q == SMSEC_UNLOCKED
		|=> state_q == SMSEC_UNLOCKED && pw_q == $past(REQ_IN.pw) && !RSP_OUT.aborted)
		else $error("set password not replaced");

	a_unlock_noop: assert property (@(posedge REF_CLK_IN)
		disable iff (!PWR_ONN_IN || !RSTN_IN)
		REQ_IN.valid && REQ_IN.cmd == SMSEC_CMD_UNLOCK && state_q == SMSEC_UNLOCKED
		|=> state_q == SMSEC_UNLOCKED && !RSP_OUT.aborted)
		else $error("unlock while unlocked misbehaved");

	a_lock_move: assert property (@(posedge REF_CLK_IN) disable iff (!PWR_ONN_IN)
		REQ_IN.valid && REQ_IN.cmd == SMSEC_CMD_LOCK && state_q == SMSEC_UNLOCKED
		|=> state_q == SMSEC_LOCKED)
		else $error("lock did not lock");

	a_freeze_move: assert property (@(posedge REF_CLK_IN) disable iff (!PWR_ONN_IN)
		REQ_IN.valid && REQ_IN.cmd == SMSEC_CMD_FREEZE && state_q == SMSEC_UNLOCKED
		|=> state_q == SMSEC_FROZEN)
		else $error("freeze-lock did not freeze");

	// ------------------------------------------------------------
	// Checks: locked and frozen states
	// ------------------------------------------------------------
	a_locked_abort: assert property (@(posedge REF_CLK_IN)
		disable iff (!PWR_ONN_IN || !RSTN_IN)
		REQ_IN.valid && state_q == SMSEC_LOCKED && REQ_IN.cmd == SMSEC_CMD_SETMAX
		|=> RSP_OUT.aborted && $stable(max_q))
		else $error("locked set max not aborted");

	a_locked_pw_abort: assert property (@(posedge REF_CLK_IN)
		disable iff (!PWR_ONN_IN || !RSTN_IN)
		REQ_IN.valid && state_q == SMSEC_LOCKED && REQ_IN.cmd == SMSEC_CMD_SETPW
		|=> RSP_OUT.aborted && $stable(pw_q) && state_q == SMSEC_LOCKED)
		else $error("locked set password not aborted");

	a_relock_ok: assert property (@(posedge REF_CLK_IN)
		disable iff (!PWR_ONN_IN || !RSTN_IN)
		REQ_IN.valid && state_q == SMSEC_LOCKED && REQ_IN.cmd == SMSEC_CMD_LOCK
		|=> !RSP_OUT.aborted && state_q == SMSEC_LOCKED)
		else $error("repeated lock misbehaved");

	a_unlock_back: assert property (@(posedge REF_CLK_IN) disable iff (!PWR_ONN_IN)
		REQ_IN.valid && REQ_IN.cmd == SMSEC_CMD_UNLOCK && state_q == SMSEC_LOCKED
		|=> state_q == SMSEC_UNLOCKED)
		else $error("unlock did not unlock");

	a_frozen_stays: assert property (@(posedge REF_CLK_IN) disable iff (!PWR_ONN_IN)
		state_q == SMSEC_FROZEN |=> state_q == SMSEC_FROZEN)
		else $error("left frozen state");

	a_frozen_abort: assert property (@(posedge REF_CLK_IN)
		disable iff (!PWR_ONN_IN || !RSTN_IN)
		REQ_IN.valid && state_q == SMSEC_FROZEN && REQ_IN.cmd != SMSEC_CMD_NONE
		|=> RSP_OUT.aborted)
		else $error("frozen did not abort");

	// ------------------------------------------------------------
	// Checks: completion status
	// ------------------------------------------------------------
	a_done_pulse: assert property (@(posedge REF_CLK_IN)
		disable iff (!PWR_ONN_IN || !RSTN_IN)
		REQ_IN.valid && REQ_IN.cmd != SMSEC_CMD_NONE |=> RSP_OUT.done)
		else $error("command not completed");

	// Aborted commands must leave every stored value alone
	a_abort_keeps: assert property (@(posedge REF_CLK_IN)
		disable iff (!PWR_ONN_IN || !RSTN_IN)
		RSP_OUT.aborted |-> $stable(max_q) && $stable(pw_q))
		else $error("aborted command changed stored value");

endmodule : smsec_top

`default_nettype wire

//--- design/smsec_pkg.sv
// Purpose: Shared types and constants for the max-address security machine
// Assumes: Commands arrive already decoded from the command register path
// Notes:   Widths are fixed here because the request struct carries them
//
// Functional notes
// - Power-on puts the machine in inactive state, no password, extension disabled.
// - Inactive or unlocked: execute set-max-address, keep current state.
// - Inactive: abort lock, unlock and freeze-lock, stay inactive.
// - Inactive: set-password moves to unlocked with password established.
// - Unlocked: set-password replaces stored password, stay unlocked.
// - Unlocked: unlock command is not carried out, stay unlocked.
// - Unlocked: lock command moves to locked state.
// - Unlocked: freeze-lock command moves to frozen state.
// - Locked: abort set-max-address and set-password, stay locked.
// - Locked: further lock executes without error, stay locked.
// - Locked: unlock returns to unlocked state.
// - Locked: freeze-lock may enter frozen state; optional.
// - Frozen: abort every set-max command, stay frozen.
// - Frozen is left only by power cycle, never by command.
// - Unlocked, locked or frozen: identify word 86 bit 8 reads one.
// - Password survives hardware and software resets, lost on power cycle.
package smsec_pkg;

	localparam int          SMSEC_PW_W        = 32;
	localparam int          SMSEC_ADDR_W      = 48;
	localparam int          SMSEC_IDW_BIT     = 8;
	localparam int          SMSEC_IDW_WORD    = 86;
	localparam logic        SMSEC_FRZ_FROM_LK = 1'b1;
	localparam logic [47:0] SMSEC_MAX_RST     = 48'h0000_0000_0000;
	localparam logic [31:0] SMSEC_PW_RST      = 32'h0000_0000;

	typedef enum logic [2:0] {
		SMSEC_CMD_NONE,
		SMSEC_CMD_SETMAX,
		SMSEC_CMD_SETPW,
		SMSEC_CMD_LOCK,
		SMSEC_CMD_UNLOCK,
		SMSEC_CMD_FREEZE
	} smsec_cmd_e;

	typedef enum logic [1:0] {
		SMSEC_INACTIVE,
		SMSEC_UNLOCKED,
		SMSEC_LOCKED,
		SMSEC_FROZEN
	} smsec_state_e;

	typedef struct packed {
		logic                    valid;
		smsec_cmd_e              cmd;
		logic [SMSEC_ADDR_W-1:0] addr;
		logic [SMSEC_PW_W-1:0]   pw;
	} smsec_req_s;

	typedef struct packed {
		logic done;
		logic aborted;
	} smsec_rsp_s;

endpackage : smsec_pkg

//--- test/smsec_host.sv
// Purpose: Host model issuing decoded max-address commands
// Assumes: One request at a time, launched on the falling edge
// Notes:   Released fields show inverted data, never stale values
`timescale 1ns/1ps
`default_nettype none

module smsec_host import smsec_pkg::*; (
	input  wire logic       clk_in,
	output var  smsec_req_s req_out
);
	initial req_out = '0;

	// Freeze sent in whatever state the bench asks, lock only when told
	// Set-max assumed preceded by a native-max read upstream
	task automatic send(input smsec_cmd_e cmd, input logic [SMSEC_ADDR_W-1:0] addr,
		input logic [SMSEC_PW_W-1:0] pw);
		@(negedge clk_in);
		req_out = '{valid: 1'b1, cmd: cmd, addr: addr, pw: pw};
		@(negedge clk_in);
		req_out = '{valid: 1'b0, cmd: SMSEC_CMD_NONE, addr: ~addr, pw: ~pw};
	endtask : send
endmodule : smsec_host
`default_nettype wire

//--- test/test_set_max_security_fsm.sv
// Purpose: Self-checking bench for the max-address security machine
// Assumes: Answer and state show on the taking edge and are checked half a cycle later
// Notes:   Password has no output, so it is judged through state only
`timescale 1ns/1ps
`default_nettype none

module test_set_max_security_fsm import smsec_pkg::*; ;
	logic                    ref_clk = 1'b0;
	logic                    pwr_onn = 1'b0;
	logic                    rstn    = 1'b0;
	smsec_req_s              req;
	smsec_rsp_s              rsp;
	logic [SMSEC_ADDR_W-1:0] max_addr;
	logic                    sec_en;
	logic [1:0]              state;
	int                      err_count   = 0;
	int                      comparisons = 0;

	always #2 ref_clk = ~ref_clk;

	smsec_host smsec_host_i (.clk_in(ref_clk), .req_out(req));
	smsec_top smsec_top_i (.REF_CLK_IN(ref_clk), .PWR_ONN_IN(pwr_onn), .RSTN_IN(rstn),
		.REQ_IN(req), .RSP_OUT(rsp), .MAX_ADDR_OUT(max_addr), .SEC_ENABLED_OUT(sec_en),
		.STATE_OUT(state));

	// ----------------------------------------
	// Checking helpers
	// ----------------------------------------
	task automatic chk(input string name, input logic [47:0] seen, input logic [47:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
		end
	endtask : chk

	// Done is looked at in the one cycle it stands
	task automatic run(input smsec_cmd_e cmd, input logic [47:0] a, input logic ab,
		input logic [1:0] st);
		smsec_host_i.send(cmd, a, ~a[31:0]);
		chk("done", rsp.done, 1'b1);
		chk("aborted", rsp.aborted, ab);
		chk("state", state, st);
		chk("sec_bit", sec_en, st != 2'h0);
	endtask : run

	task automatic inactive_case();
		chk("reset_state", state, 2'h0);
		chk("reset_max", max_addr, SMSEC_MAX_RST);
		run(SMSEC_CMD_LOCK, 48'h1, 1'b1, 2'h0);
		run(SMSEC_CMD_UNLOCK, 48'h2, 1'b1, 2'h0);
		run(SMSEC_CMD_FREEZE, 48'h3, 1'b1, 2'h0);
		run(SMSEC_CMD_SETMAX, 48'hFFFF_0000_1234, 1'b0, 2'h0);
		chk("max", max_addr, 48'hFFFF_0000_1234);
	endtask : inactive_case

	task automatic unlocked_case();
		run(SMSEC_CMD_SETPW, 48'h5, 1'b0, 2'h1);
		run(SMSEC_CMD_SETPW, 48'h6, 1'b0, 2'h1);
		run(SMSEC_CMD_UNLOCK, 48'h7, 1'b0, 2'h1);
		run(SMSEC_CMD_SETMAX, 48'h0000_8000_0001, 1'b0, 2'h1);
		chk("max", max_addr, 48'h0000_8000_0001);
		run(SMSEC_CMD_LOCK, 48'h8, 1'b0, 2'h2);
	endtask : unlocked_case

	task automatic locked_case();
		run(SMSEC_CMD_SETMAX, 48'h9, 1'b1, 2'h2);
		run(SMSEC_CMD_SETPW, 48'hA, 1'b1, 2'h2);
		chk("max", max_addr, 48'h0000_8000_0001);
		run(SMSEC_CMD_LOCK, 48'hB, 1'b0, 2'h2);
		run(SMSEC_CMD_UNLOCK, 48'hC, 1'b0, 2'h1);
		run(SMSEC_CMD_FREEZE, 48'hD, 1'b0, 2'h3);
	endtask : locked_case

	task automatic frozen_case();
		for (int i = 1; i <= 5; i++) begin
			run(smsec_cmd_e'(i[2:0]), 48'hE, 1'b1, 2'h3);
		end
		chk("max", max_addr, 48'h0000_8000_0001);
		@(negedge ref_clk) rstn = 1'b0;
		@(negedge ref_clk) rstn = 1'b1;
		chk("rst_state", state, 2'h3);
		@(negedge ref_clk) pwr_onn = 1'b0;
		@(negedge ref_clk) pwr_onn = 1'b1;
		chk("pwr_state", state, 2'h0);
		chk("pwr_bit", sec_en, 1'b0);
	endtask : frozen_case

	task automatic finish_test();
		$display("comparisons %0d err_count %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : finish_test

	initial begin
		repeat (5) @(posedge ref_clk);
		@(negedge ref_clk);
		pwr_onn = 1'b1;
		rstn    = 1'b1;
		inactive_case();
		unlocked_case();
		locked_case();
		frozen_case();
		finish_test();
	end
endmodule : test_set_max_security_fsm
`default_nettype wire
